/* pkg/tpwm_pkg.sv */
// package: register map, field positions and reset values of the timer channel block
// assumes a 32-bit apb slave with one aligned word per register
package tpwm_pkg;
	// register byte offsets
	localparam logic [7:0] off_ctrl      = 8'h00;  // clock source, prescale, center align
	localparam logic [7:0] off_count     = 8'h04;  // counter, read only
	localparam logic [7:0] off_mod_high  = 8'h08;
	localparam logic [7:0] off_mod_low   = 8'h0c;
	localparam logic [7:0] off_ch_ctrl   = 8'h10;  // channel control: mode and edge select
	localparam logic [7:0] off_val_high  = 8'h14;
	localparam logic [7:0] off_val_low   = 8'h18;
	localparam logic [7:0] off_status    = 8'h1c;  // sticky flags, clear on read
	localparam logic [7:0] off_mask      = 8'h20;  // interrupt mask
	// ctrl fields
	localparam int ctrl_clks_lsb  = 0;   // 2 bits
	localparam int ctrl_ps_lsb    = 2;   // 3 bits, prescale 2**ps
	localparam int ctrl_center_align_select_bit = 5;
	// channel control fields
	localparam int ch_mode_lsb = 0;      // 2 bits
	localparam int ch_els_lsb  = 2;      // 2 bits, b:a
	// status/mask bits
	localparam int st_chf_bit = 0;
	localparam int st_tof_bit = 1;
	// reset values
	localparam logic [15:0] mod_reset = 16'hffff;
	localparam logic [15:0] val_reset = 16'h0000;
	localparam logic [1:0]  clks_off  = 2'h0;
	// channel modes
	typedef enum logic [1:0] {
		mode_none    = 2'b00,
		mode_compare = 2'b01,
		mode_edge_aligned_pwm    = 2'b10
	} ch_mode_t;
endpackage

/* rtl/timer_channel_compare_pwm.sv */
// timer counter with one output compare / edge-aligned pwm channel and apb registers
// assumes pclk at 50 MHz, software as the only partner
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module timer_channel_compare_pwm
	import tpwm_pkg::*;
#(
	parameter int cnt_width = 16
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// channel pin
	output logic             ch_out,
	output logic             ch_oe,
	// interrupt
	output logic             irq
);

	// register state
	logic [7:0]           ctrl, next_ctrl;
	logic [cnt_width-1:0] modulus, next_modulus;
	logic [7:0]           mod_high_buf, next_mod_high_buf;
	logic [3:0]           ch_ctrl, next_ch_ctrl;
	logic [7:0]           val_high_buf, next_val_high_buf;
	logic [7:0]           val_low_buf, next_val_low_buf;
	logic                 got_high, next_got_high;
	logic                 got_low, next_got_low;
	logic                 pending, next_pending;
	logic [cnt_width-1:0] chan_val, next_chan_val;
	logic [1:0]           status, next_status;
	logic [1:0]           mask, next_mask;
	// counter state
	logic [cnt_width-1:0] count, next_count;
	logic [7:0]           presc, next_presc;
	logic                 pwm, next_pwm;
	logic [31:0]          next_prdata;

	// decoded fields
	logic       wr_en, rd_en, rd_setup, tick, wrap, match, hit_mod_step, running;
	logic [1:0] next_els;
	ch_mode_t   mode;
	logic       edge_aligned_pwm_on, next_edge_aligned_pwm_on;
	logic [7:0] presc_top;
	// pin outputs ahead of their flops
	logic       next_ch_out, next_ch_oe;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// pwm mode selected and center align clear
	function automatic logic edge_aligned_pwm_sel(input logic [3:0] cc, input logic [7:0] ct);
		return ch_mode_t'(cc[ch_mode_lsb +: 2]) == mode_edge_aligned_pwm && !ct[ctrl_center_align_select_bit];
	endfunction

	// apb strobes, zero wait state
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign rd_setup = psel && !penable && !pwrite; // read data captured here
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	assign mode      = ch_mode_t'(ch_ctrl[ch_mode_lsb +: 2]);
	assign next_els  = next_ch_ctrl[ch_els_lsb +: 2];
	assign running   = ctrl[ctrl_clks_lsb +: 2] != clks_off;
	assign edge_aligned_pwm_on   = edge_aligned_pwm_sel(ch_ctrl, ctrl);
	assign next_edge_aligned_pwm_on = edge_aligned_pwm_sel(next_ch_ctrl, next_ctrl);
	assign presc_top = 8'((9'h1 << ctrl[ctrl_ps_lsb +: 3]) - 9'h1);
	assign tick      = running && presc == presc_top;
	assign wrap      = tick && count == modulus;
	assign match     = tick && next_count == chan_val;
	assign hit_mod_step = tick && count == cnt_width'(modulus - 1'b1);

	// counter and prescaler
	always_comb begin
		next_presc = presc;
		next_count = count;
		if (running) begin
			next_presc = tick ? 8'h00 : 8'(presc + 8'h01);
			if (tick) begin
				next_count = wrap ? '0 : cnt_width'(count + 1'b1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= 8'h00;
			count <= '0;
		end else begin
			presc <= next_presc;
			count <= next_count;
		end
	end

	// register writes, value buffering and transfer
	always_comb begin
		next_ctrl         = ctrl;
		next_modulus      = modulus;
		next_mod_high_buf = mod_high_buf;
		next_ch_ctrl      = ch_ctrl;
		next_val_high_buf = val_high_buf;
		next_val_low_buf  = val_low_buf;
		next_got_high     = got_high;
		next_got_low      = got_low;
		next_pending      = pending;
		next_chan_val     = chan_val;
		next_mask         = mask;
		if (wr_en) begin
			if (addr_is(paddr, off_ctrl)) begin
				next_ctrl = pwdata[7:0];
			end
			if (addr_is(paddr, off_mod_high)) begin
				next_mod_high_buf = pwdata[7:0];
			end
			if (addr_is(paddr, off_mod_low)) begin
				next_modulus = cnt_width'({mod_high_buf, pwdata[7:0]});
			end
			if (addr_is(paddr, off_mask)) begin
				next_mask = pwdata[1:0];
			end
			if (addr_is(paddr, off_ch_ctrl)) begin
				next_ch_ctrl  = pwdata[3:0];
				next_got_high = 1'b0;
				next_got_low  = 1'b0;
			end
			if (addr_is(paddr, off_val_high)) begin
				next_val_high_buf = pwdata[7:0];
				next_got_high     = 1'b1;
			end
			if (addr_is(paddr, off_val_low)) begin
				next_val_low_buf = pwdata[7:0];
				next_got_low     = 1'b1;
			end
		end
		// pair complete: load now or arm the deferred transfer
		if (next_got_high && next_got_low) begin
			next_got_high = 1'b0;
			next_got_low  = 1'b0;
			if (!running) begin
				next_chan_val = cnt_width'({next_val_high_buf, next_val_low_buf});
				next_pending  = 1'b0;
			end else begin
				next_pending = 1'b1;
			end
		end else if (pending) begin
			if (!running) begin
				next_chan_val = cnt_width'({val_high_buf, val_low_buf});
				next_pending  = 1'b0;
			end else if (edge_aligned_pwm_on ? hit_mod_step : tick) begin
				next_chan_val = cnt_width'({val_high_buf, val_low_buf});
				next_pending  = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl         <= 8'h00;
			modulus      <= cnt_width'(mod_reset);
			mod_high_buf <= 8'h00;
			ch_ctrl      <= 4'h0;
			val_high_buf <= 8'h00;
			val_low_buf  <= 8'h00;
			got_high     <= 1'b0;
			got_low      <= 1'b0;
			pending      <= 1'b0;
			chan_val     <= cnt_width'(val_reset);
			mask         <= 2'h0;
		end else begin
			ctrl         <= next_ctrl;
			modulus      <= next_modulus;
			mod_high_buf <= next_mod_high_buf;
			ch_ctrl      <= next_ch_ctrl;
			val_high_buf <= next_val_high_buf;
			val_low_buf  <= next_val_low_buf;
			got_high     <= next_got_high;
			got_low      <= next_got_low;
			pending      <= next_pending;
			chan_val     <= next_chan_val;
			mask         <= next_mask;
		end
	end

	// sticky flags: set wins over clear-on-read
	always_comb begin
		next_status = status;
		if (rd_en && addr_is(paddr, off_status)) begin
			next_status = 2'h0;
		end
		if (match && mode != mode_none) begin
			next_status[st_chf_bit] = 1'b1;
		end
		if (wrap) begin
			next_status[st_tof_bit] = 1'b1;
		end
	end

	// pwm waveform, high-true internally
	always_comb begin
		next_pwm = pwm;
		if (edge_aligned_pwm_on && tick) begin
			if (wrap) begin
				next_pwm = chan_val != '0;
			end else if (next_count == chan_val) begin
				next_pwm = 1'b0;
			end
		end else if (!edge_aligned_pwm_on) begin
			next_pwm = 1'b0;
		end
	end

	// read mux, loaded in the setup cycle and held through access
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				off_ctrl:     next_prdata = {24'h000000, ctrl};
				off_count:    next_prdata = 32'(count);
				off_mod_high: next_prdata = {24'h000000, 8'(modulus >> 8)};
				off_mod_low:  next_prdata = {24'h000000, 8'(modulus)};
				off_ch_ctrl:  next_prdata = {28'h0000000, ch_ctrl};
				off_val_high: next_prdata = {24'h000000, 8'(chan_val >> 8)};
				off_val_low:  next_prdata = {24'h000000, 8'(chan_val)};
				off_status:   next_prdata = {30'h00000000, status};
				off_mask:     next_prdata = {30'h00000000, mask};
				default:      next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// pin level and enable follow the control values written at this edge
	always_comb begin
		next_ch_out = next_els[0] ? !next_pwm : next_pwm;
		next_ch_oe  = next_edge_aligned_pwm_on && next_els != 2'b00;
	end

	// sticky flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 2'h0;
		end else begin
			status <= next_status;
		end
	end

	// internal waveform
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm <= 1'b0;
		end else begin
			pwm <= next_pwm;
		end
	end

	// bus read data and pin outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			ch_out <= 1'b0;
			ch_oe  <= 1'b0;
		end else begin
			prdata <= next_prdata;
			ch_out <= next_ch_out;
			ch_oe  <= next_ch_oe;
		end
	end

	// one level interrupt from unmasked flags
	assign irq = |(status & mask);

endmodule

/* tb/tpwm_properties.sv */
// checker: port-level properties of the timer channel block
// assumes it is bound onto timer_channel_compare_pwm
`timescale 1ns/1ps
module tpwm_properties
	import tpwm_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pin and interrupt
	input wire logic        ch_out,
	input wire logic        ch_oe,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// committed write to channel control
	wire logic ctl_wr = psel && penable && pwrite && (paddr == off_ch_ctrl);
	// committed write to either control register
	wire logic cfg_wr = ctl_wr || (psel && penable && pwrite && (paddr == off_ctrl));
	ready_high_a: assert property (pready && !pslverr) else $error("apb answer wrong");
	unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 8'h3c |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	oe_cause_a: assert property ($changed(ch_oe) |-> $past(cfg_wr))
		else $error("pin enable moved without write");
	oe_rise_a: assert property ($rose(ch_oe) |-> ($past(ctl_wr) ?
		($past(pwdata[3:2]) != 2'b00 && $past(pwdata[1:0]) == mode_edge_aligned_pwm)
		: !$past(pwdata[ctrl_center_align_select_bit]))) else $error("pin enabled wrongly");
	oe_fall_a: assert property ($fell(ch_oe) |-> ($past(ctl_wr) ?
		($past(pwdata[3:2]) == 2'b00 || $past(pwdata[1:0]) != mode_edge_aligned_pwm)
		: $past(pwdata[ctrl_center_align_select_bit]))) else $error("pin released wrongly");
	irq_fall_a: assert property ($fell(irq) |-> $past(psel)
		&& ($past(paddr) == off_status || $past(paddr) == off_mask)) else $error("irq fell alone");
	irq_quiet_a: assert property (psel && penable && pwrite && paddr == off_mask && pwdata == 0
		|=> !irq) else $error("masked irq raised");
endmodule
bind timer_channel_compare_pwm tpwm_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_out(ch_out), .ch_oe(ch_oe),
	.irq(irq));

/* tb/tb.sv */
// testbench: registers, pwm waveform, byte pairing and interrupt of the timer channel
// assumes pclk 20 ns and zero-wait apb answers
`timescale 1ns/1ps
module tb
	import tpwm_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, ch_out, ch_oe, irq;
	int          fail_count = 0, compares = 0, cycles = 0, n;
	timer_channel_compare_pwm #(.cnt_width(16)) u_timer_channel_compare_pwm (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch_out(ch_out), .ch_oe(ch_oe), .irq(irq));
	always #10 pclk = ~pclk;
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask
	// one apb transfer, held until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask
	task pair(input logic [15:0] v);
		apb(1'b1, off_val_high, {24'h0, v[15:8]});
		apb(1'b1, off_val_low, {24'h0, v[7:0]});
	endtask
	// high cycles over ten periods of modulus 3
	task duty(input int e, input string s);
		repeat (8) @(posedge pclk);
		n = 0;
		repeat (40) begin
			@(posedge pclk);
			if (ch_out === 1'b1) n++;
		end
		chk(s, 32'(e), 32'(n));
	endtask
	task t_reset;
		rd(off_ctrl, 32'h0, "ctrl");
		rd(off_mask, 32'h0, "mask");
		rd(off_status, 32'h0, "status");
		rd(8'h3c, 32'h0, "unmapped");
		chk("oe", 32'h0, {31'h0, ch_oe});
	endtask
	task t_pwm;
		apb(1'b1, off_ch_ctrl, 32'h02); // pwm mode, pin still released
		apb(1'b1, off_mod_high, 32'h0);
		apb(1'b1, off_mod_low, 32'h03);
		pair(16'h0001);
		apb(1'b1, off_ctrl, 32'h01);
		do apb(1'b0, off_status, 32'h0); while (q[st_tof_bit] !== 1'b1);
		chk("oe_parked", 32'h0, {31'h0, ch_oe});
		apb(1'b1, off_ch_ctrl, 32'h0a); // hand the pin over, select 10
		duty(10, "duty1");
		chk("oe", 32'h1, {31'h0, ch_oe});
		pair(16'h0002);
		duty(20, "duty2");
	endtask
	task t_pairing;
		apb(1'b1, off_val_low, 32'h03);
		duty(20, "lone");
		apb(1'b1, off_ch_ctrl, 32'h0a);
		apb(1'b1, off_val_high, 32'h0);
		duty(20, "restart");
		apb(1'b1, off_val_low, 32'h0);
		duty(0, "zero");
		pair(16'h0005);
		duty(40, "full");
	endtask
	task t_polarity;
		pair(16'h0001);
		apb(1'b1, off_ch_ctrl, 32'h06);
		duty(30, "low_true");
		apb(1'b1, off_ch_ctrl, 32'h02);
		@(posedge pclk);
		chk("oe_off", 32'h0, {31'h0, ch_oe});
	endtask
	task t_irq;
		apb(1'b1, off_ctrl, 32'h0);
		chk("irq_masked", 32'h0, {31'h0, irq});
		rd(off_status, 32'h3, "flags");
		repeat (8) @(posedge pclk);
		rd(off_status, 32'h0, "stopped");
		apb(1'b1, off_mask, 32'h3);
		apb(1'b1, off_ctrl, 32'h01);
		repeat (8) @(posedge pclk);
		chk("irq_on", 32'h1, {31'h0, irq});
		apb(1'b1, off_ctrl, 32'h0);
		rd(off_status, 32'h3, "flags2");
		@(posedge pclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		apb(1'b1, off_ctrl, 32'h01);
		repeat (8) @(posedge pclk);
		chk("irq_on2", 32'h1, {31'h0, irq});
		apb(1'b1, off_mask, 32'h0);
		@(posedge pclk);
		chk("irq_masked2", 32'h0, {31'h0, irq});
	endtask
	// compare mode: buffered value moves at the next prescaled step
	task t_compare;
		apb(1'b1, off_ch_ctrl, 32'h01);
		apb(1'b1, off_ctrl, 32'h0d); // divide by 8
		pair(16'h0002);
		repeat (10) @(posedge pclk);
		rd(off_val_low, 32'h02, "cmp_load");
		chk("oe_cmp", 32'h0, {31'h0, ch_oe});
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pwm;
		t_pairing;
		t_polarity;
		t_irq;
		t_compare;
		tally_and_finish;
	end
endmodule
